/* File: hw/adm_pkg.sv */
package adm_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_INS    = 8'h04;
  localparam logic [7:0] OFS_DROP   = 8'h08;
  localparam logic [7:0] OFS_JOINT  = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // ==========================================================================
  // Control register fields
  localparam int CTRL_OC12     = 0;
  localparam int CTRL_SCHEME   = 1;
  localparam int CTRL_SCRAMBLE = 3;
  localparam int CTRL_DI_MODE  = 4;
  localparam int CTRL_DI_STS1  = 5;
  localparam int CTRL_FILL     = 8;
  localparam int CTRL_DI_SRC   = 10;

  // Channel code fields: group number in the high nibble, member or index low.
  localparam int CHAN_GROUP = 4;

  // Status register fields.
  localparam int STAT_INS   = 0;
  localparam int STAT_DROP  = 4;
  localparam int STAT_LEVEL = 8;

  // ==========================================================================
  // Values after reset
  localparam logic        RST_OC12     = 1'b0;
  localparam logic        RST_SCRAMBLE = 1'b1;
  localparam logic [3:0]  RST_SLOT     = 4'h0;
  localparam logic [31:0] RST_RDATA    = 32'h0000_0000;
  localparam logic [7:0]  RST_BYTE     = 8'h00;

  // ==========================================================================
  // Line and frame figures
  localparam logic [3:0] OC3_LAST_SLOT  = 4'h2;
  localparam logic [3:0] OC12_LAST_SLOT = 4'hB;
  localparam logic [3:0] PAIR_GROUPS    = 4'h4;
  localparam logic [3:0] PAIR_MEMBERS   = 4'h3;
  localparam logic [3:0] LINEAR_MAX     = 4'hC;
  localparam logic [9:0] FRAME_LAST     = 10'h329;
  localparam logic [9:0] FIXED_BYTES    = 10'h003;
  localparam logic [6:0] LFSR_SEED      = 7'h7F;
  localparam int         FIFO_DEPTH     = 32;
  localparam int         FIFO_MARGIN    = 4;
  localparam int         BYTE_W         = 8;

  // ==========================================================================
  // Modes
  typedef enum logic [1:0] {SCHEME_PAIR, SCHEME_TRANSMIT, SCHEME_MUX} scheme_t;
  typedef enum logic [1:0] {FILL_SAME, FILL_UNEQ, FILL_EXT} fill_t;
  typedef enum logic [1:0] {DI_EXT, DI_UNEQ, DI_LOOP} di_src_t;

endpackage

/* File: hw/fifo_if.sv */
`timescale 1ns/100ps
interface fifo_if #(
  parameter int W  = 8,
  parameter int CW = 6
);
  logic          wr_valid;
  logic          wr_ready;
  logic [W-1:0]  wr_data;
  logic          rd_valid;
  logic          rd_ready;
  logic [W-1:0]  rd_data;
  logic [CW-1:0] level;

  modport buffer (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data, level);
  modport user   (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data, level);
endinterface

/* File: hw/byte_fifo.sv */
`timescale 1ns/100ps
module byte_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  fifo_if.buffer   q
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr_ff;
  logic [AW-1:0] rptr_ff;
  logic [AW:0]   level_ff;
  logic          push;
  logic          pop;

  assign push       = q.wr_valid && q.wr_ready;
  assign pop        = q.rd_valid && q.rd_ready;
  assign q.wr_ready = level_ff != (AW+1)'(DEPTH);
  assign q.rd_valid = level_ff != '0;
  assign q.rd_data  = mem[rptr_ff];
  assign q.level    = level_ff;

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wptr_ff] <= q.wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr_ff  <= '0;
      rptr_ff  <= '0;
      level_ff <= '0;
    end else if (ce) begin
      if (push) begin
        wptr_ff <= wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= rptr_ff + 1'b1;
      end
      if (push && !pop) begin
        level_ff <= level_ff + 1'b1;
      end else if (pop && !push) begin
        level_ff <= level_ff - 1'b1;
      end
    end
  end
endmodule

/* File: hw/sts1_scrambler.sv */
`timescale 1ns/100ps
module sts1_scrambler (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       en,
  input  wire logic       in_valid,
  input  wire logic       in_fs,
  input  wire logic [7:0] in_data,
  output logic            out_valid,
  output logic            out_fs,
  output logic [7:0]      out_data
);
  logic [9:0] pos_ff;
  logic [6:0] lfsr_ff;
  logic [9:0] pos;
  logic [7:0] key;
  logic [6:0] nxt_lfsr;

  // Eight steps of the 1+x^6+x^7 generator; the key byte is taken MSB first.
  always_comb begin
    nxt_lfsr = lfsr_ff;
    key      = '0;
    for (int i = 0; i < 8; i++) begin
      key[7-i] = nxt_lfsr[6];
      nxt_lfsr = {nxt_lfsr[5:0], nxt_lfsr[6] ^ nxt_lfsr[5]};
    end
  end

  assign pos = in_fs ? '0 : pos_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_ff    <= '0;
      lfsr_ff   <= adm_pkg::LFSR_SEED;
      out_valid <= 1'b0;
      out_fs    <= 1'b0;
      out_data  <= adm_pkg::RST_BYTE;
    end else if (ce) begin
      out_valid <= in_valid;
      out_fs    <= in_valid && in_fs;
      if (in_valid) begin
        pos_ff <= (pos == adm_pkg::FRAME_LAST) ? '0 : pos + 10'h001;
        // Framing and trace bytes pass clear and hold the generator at its seed.
        if (pos < adm_pkg::FIXED_BYTES) begin
          lfsr_ff  <= adm_pkg::LFSR_SEED; // R9
          out_data <= in_data;
        end else begin
          lfsr_ff  <= nxt_lfsr; // R9
          out_data <= en ? (in_data ^ key) : in_data; // R8
        end
      end
    end
  end
endmodule

/* File: hw/sts1_channel_add_drop_mux.sv */
// Overview of operation
// R1 - Test STS-1 goes into the insert tributary; OC-3 accepts channels 1 to 3.
// R2 - OC-12 channel selects accept pair 1,1..4,3 or index 1..12 per numbering scheme.
// R3 - Pair (n,m) is slot (m-1)*4+n; mux-order index (n-1)*3+m names that pair.
// R4 - Fill same: every other tributary copies the inserted payload.
// R5 - Fill unequipped: every other tributary carries all zero bytes.
// R6 - Fill external: others carry the electrical STS-1 input; never on OC-12.
// R7 - Receive test STS-1 is taken from the drop tributary; 1..3 or 1..12.
// R8 - Electrical STS-1 scrambler switchable; frame-synchronous, length 127.
// R9 - Generator 1+x^6+x^7, seeded all ones per frame, first three bytes clear.
// R10 - Joint select sets insert and drop tributaries together in one write.
// R11 - Joint select acts only in drop-and-insert mode, ignored otherwise.
// R12 - Drop-and-insert payload source applies only when payload is STS-1.
// R13 - Source external: inserted tributary carries the electrical STS-1 input.
// R14 - Source unequipped: inserted tributary carries all zero bytes.
// R15 - Source loop: dropped tributary bytes are resent in the inserted one.
`timescale 1ns/100ps
module sts1_channel_add_drop_mux #(
  parameter int FIFO_DEPTH = adm_pkg::FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [7:0]  tst_tx_data,
  input  wire logic        line_tx_en,
  input  wire logic        line_tx_fs,
  output logic      [7:0]  line_tx_data,
  output logic             line_tx_valid,
  output logic             line_tx_frame,
  input  wire logic [7:0]  line_rx_data,
  input  wire logic        line_rx_valid,
  input  wire logic        line_rx_fs,
  output logic      [7:0]  tst_rx_data,
  output logic             tst_rx_valid,
  output logic             tst_rx_frame,
  input  wire logic [7:0]  sts1_rx_data,
  input  wire logic        sts1_rx_valid,
  input  wire logic        sts1_rx_fs,
  output logic             sts1_rx_ready,
  output logic      [7:0]  sts1_tx_data,
  output logic             sts1_tx_valid,
  output logic             sts1_tx_frame
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  // ==========================================================================
  // Configuration state
  logic                oc12_ff;
  adm_pkg::scheme_t    scheme_ff;
  logic                scramble_ff;
  logic                di_mode_ff;
  logic                di_sts1_ff;
  adm_pkg::fill_t      fill_ff;
  adm_pkg::di_src_t    di_src_ff;
  logic [3:0]          ins_slot_ff;
  logic [3:0]          drop_slot_ff;
  logic [31:0]         reg_rdata_ff;

  // ==========================================================================
  // Datapath state
  logic [3:0]          tx_slot_ff;
  logic [7:0]          ext_hold_ff;
  logic [7:0]          line_tx_data_ff;
  logic                line_tx_valid_ff;
  logic                line_tx_frame_ff;
  logic [3:0]          rx_slot_ff;
  logic                drop_pend_ff;
  logic [7:0]          drop_byte_ff;
  logic                drop_valid_ff;
  logic                drop_frame_ff;
  logic [9:0]          sync1_ff;
  logic [9:0]          sync2_ff;
  logic                sts1_rx_ready_ff;

  logic [3:0]          last_slot;
  logic [4:0]          chan_dec;
  logic [3:0]          tx_slot;
  logic [3:0]          rx_slot;
  logic                di_active;
  adm_pkg::fill_t      fill_eff;
  logic                need_ext;
  logic [7:0]          ext_byte;
  logic [7:0]          ins_byte;
  logic [7:0]          other_byte;
  logic                drop_hit;
  logic                desc_valid;
  logic                desc_fs;
  logic [7:0]          desc_data;

  fifo_if #(.W(adm_pkg::BYTE_W), .CW(LW)) ext_q ();

  // ==========================================================================
  // Channel code decode
  // Returns {valid, zero-based transmission slot}.
  function automatic logic [4:0] chan_slot(input logic [7:0] code,
                                           input logic oc12,
                                           input adm_pkg::scheme_t scheme);
    logic [3:0] hi;
    logic [3:0] lo;
    logic [3:0] t;
    logic       ok;
    hi = code[7:4];
    lo = code[3:0];
    t  = 4'h1;
    ok = 1'b0;
    if (!oc12) begin
      ok = (hi == 4'h0) && (lo >= 4'h1) && (lo <= adm_pkg::OC3_LAST_SLOT + 4'h1); // R1 R7
      t  = lo;
    end else if (scheme == adm_pkg::SCHEME_PAIR) begin
      ok = (hi >= 4'h1) && (hi <= adm_pkg::PAIR_GROUPS) &&
           (lo >= 4'h1) && (lo <= adm_pkg::PAIR_MEMBERS); // R2
      t  = 4'((lo - 4'h1) * adm_pkg::PAIR_GROUPS + hi); // R3
    end else begin
      ok = (hi == 4'h0) && (lo >= 4'h1) && (lo <= adm_pkg::LINEAR_MAX); // R2
      if (scheme == adm_pkg::SCHEME_MUX) begin
        t = 4'(((lo - 4'h1) % adm_pkg::PAIR_MEMBERS) * adm_pkg::PAIR_GROUPS
               + (lo - 4'h1) / adm_pkg::PAIR_MEMBERS + 4'h1); // R3
      end else begin
        t = lo;
      end
    end
    return {ok, 4'(t - 4'h1)};
  endfunction

  assign chan_dec  = chan_slot(reg_wdata[7:0], oc12_ff, scheme_ff);
  assign last_slot = oc12_ff ? adm_pkg::OC12_LAST_SLOT : adm_pkg::OC3_LAST_SLOT;

  // ==========================================================================
  // Register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oc12_ff     <= adm_pkg::RST_OC12;
      scheme_ff   <= adm_pkg::SCHEME_PAIR;
      scramble_ff <= adm_pkg::RST_SCRAMBLE;
      di_mode_ff  <= 1'b0;
      di_sts1_ff  <= 1'b0;
      fill_ff     <= adm_pkg::FILL_SAME;
      di_src_ff   <= adm_pkg::DI_EXT;
    end else if (ce && reg_wr && reg_addr == adm_pkg::OFS_CTRL) begin
      oc12_ff     <= reg_wdata[adm_pkg::CTRL_OC12];
      scheme_ff   <= adm_pkg::scheme_t'(reg_wdata[adm_pkg::CTRL_SCHEME +: 2]);
      scramble_ff <= reg_wdata[adm_pkg::CTRL_SCRAMBLE]; // R8
      di_mode_ff  <= reg_wdata[adm_pkg::CTRL_DI_MODE];
      di_sts1_ff  <= reg_wdata[adm_pkg::CTRL_DI_STS1];
      // External fill is refused together with OC-12; the old fill stays.
      if (!(reg_wdata[adm_pkg::CTRL_FILL +: 2] == adm_pkg::FILL_EXT &&
            reg_wdata[adm_pkg::CTRL_OC12])) begin
        fill_ff <= adm_pkg::fill_t'(reg_wdata[adm_pkg::CTRL_FILL +: 2]); // R6
      end
      di_src_ff   <= adm_pkg::di_src_t'(reg_wdata[adm_pkg::CTRL_DI_SRC +: 2]);
    end
  end

  // Out-of-range channel codes are ignored and leave the slot unchanged.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ins_slot_ff  <= adm_pkg::RST_SLOT;
      drop_slot_ff <= adm_pkg::RST_SLOT;
    end else if (ce && reg_wr && chan_dec[4]) begin
      if (reg_addr == adm_pkg::OFS_INS) begin
        ins_slot_ff <= chan_dec[3:0]; // R1
      end else if (reg_addr == adm_pkg::OFS_DROP) begin
        drop_slot_ff <= chan_dec[3:0]; // R7
      end else if (reg_addr == adm_pkg::OFS_JOINT && di_mode_ff) begin // R11
        ins_slot_ff  <= chan_dec[3:0]; // R10
        drop_slot_ff <= chan_dec[3:0]; // R10
      end
    end
  end

  // ==========================================================================
  // Register reads
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_ff <= adm_pkg::RST_RDATA;
    end else if (ce) begin
      reg_rdata_ff <= '0;
      if (!reg_rd) begin
        reg_rdata_ff <= '0;
      end else if (reg_addr == adm_pkg::OFS_CTRL) begin
        reg_rdata_ff[adm_pkg::CTRL_OC12]          <= oc12_ff;
        reg_rdata_ff[adm_pkg::CTRL_SCHEME +: 2]   <= scheme_ff;
        reg_rdata_ff[adm_pkg::CTRL_SCRAMBLE]      <= scramble_ff;
        reg_rdata_ff[adm_pkg::CTRL_DI_MODE]       <= di_mode_ff;
        reg_rdata_ff[adm_pkg::CTRL_DI_STS1]       <= di_sts1_ff;
        reg_rdata_ff[adm_pkg::CTRL_FILL +: 2]     <= fill_ff;
        reg_rdata_ff[adm_pkg::CTRL_DI_SRC +: 2]   <= di_src_ff;
      end else if (reg_addr == adm_pkg::OFS_INS) begin
        reg_rdata_ff[3:0] <= ins_slot_ff;
      end else if (reg_addr == adm_pkg::OFS_DROP) begin
        reg_rdata_ff[3:0] <= drop_slot_ff;
      end else if (reg_addr == adm_pkg::OFS_STATUS) begin
        reg_rdata_ff[adm_pkg::STAT_INS +: 4]   <= ins_slot_ff;
        reg_rdata_ff[adm_pkg::STAT_DROP +: 4]  <= drop_slot_ff;
        reg_rdata_ff[adm_pkg::STAT_LEVEL +: LW] <= ext_q.level;
      end
    end
  end

  // ==========================================================================
  // Electrical STS-1 input: synchroniser, descrambler and buffer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else if (ce) begin
      sync1_ff <= {sts1_rx_fs, sts1_rx_valid, sts1_rx_data};
      sync2_ff <= sync1_ff;
    end
  end

  sts1_scrambler u_rx_descramble (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .en        (scramble_ff),
    .in_valid  (sync2_ff[8]),
    .in_fs     (sync2_ff[9]),
    .in_data   (sync2_ff[7:0]),
    .out_valid (desc_valid),
    .out_fs    (desc_fs),
    .out_data  (desc_data)
  ); // R8

  assign ext_q.wr_valid = desc_valid;
  assign ext_q.wr_data  = desc_data;

  byte_fifo #(.W(adm_pkg::BYTE_W), .DEPTH(FIFO_DEPTH)) u_ext_fifo (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .q   (ext_q)
  );

  // Ready drops with room left for the bytes already inside the synchroniser.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sts1_rx_ready_ff <= 1'b0;
    end else if (ce) begin
      sts1_rx_ready_ff <= ext_q.level < LW'(FIFO_DEPTH - adm_pkg::FIFO_MARGIN);
    end
  end

  // ==========================================================================
  // Transmit line multiplexer
  assign di_active = di_mode_ff && di_sts1_ff; // R12
  assign fill_eff  = (fill_ff == adm_pkg::FILL_EXT && oc12_ff) ? adm_pkg::FILL_UNEQ
                                                               : fill_ff; // R6
  assign need_ext  = (fill_eff == adm_pkg::FILL_EXT) ||
                     (di_active && di_src_ff == adm_pkg::DI_EXT);
  assign tx_slot   = line_tx_fs ? 4'h0 : tx_slot_ff;

  // One electrical byte serves a whole round of tributary slots.
  assign ext_q.rd_ready = ce && line_tx_en && tx_slot == 4'h0 && need_ext;
  assign ext_byte = (tx_slot == 4'h0) ? (ext_q.rd_valid ? ext_q.rd_data : '0)
                                      : ext_hold_ff;

  always_comb begin
    ins_byte = tst_tx_data; // R1
    if (di_active) begin
      case (di_src_ff)
        adm_pkg::DI_EXT:  ins_byte = ext_byte; // R13
        adm_pkg::DI_UNEQ: ins_byte = '0; // R14
        adm_pkg::DI_LOOP: ins_byte = drop_byte_ff; // R15
        default:          ins_byte = tst_tx_data;
      endcase
    end
  end

  always_comb begin
    case (fill_eff)
      adm_pkg::FILL_SAME: other_byte = ins_byte; // R4
      adm_pkg::FILL_UNEQ: other_byte = '0; // R5
      adm_pkg::FILL_EXT:  other_byte = ext_byte; // R6
      default:            other_byte = ins_byte;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_slot_ff  <= '0;
      ext_hold_ff <= adm_pkg::RST_BYTE;
    end else if (ce && line_tx_en) begin
      tx_slot_ff <= (tx_slot >= last_slot) ? 4'h0 : tx_slot + 4'h1;
      if (tx_slot == 4'h0) begin
        ext_hold_ff <= ext_byte;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_tx_data_ff  <= adm_pkg::RST_BYTE;
      line_tx_valid_ff <= 1'b0;
      line_tx_frame_ff <= 1'b0;
    end else if (ce) begin
      line_tx_valid_ff <= line_tx_en;
      line_tx_frame_ff <= line_tx_en && line_tx_fs;
      if (line_tx_en) begin
        line_tx_data_ff <= (tx_slot == ins_slot_ff) ? ins_byte : other_byte; // R1
      end
    end
  end

  // ==========================================================================
  // Receive line demultiplexer
  assign rx_slot  = line_rx_fs ? 4'h0 : rx_slot_ff;
  assign drop_hit = line_rx_valid && rx_slot == drop_slot_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_slot_ff    <= '0;
      drop_pend_ff  <= 1'b0;
      drop_byte_ff  <= adm_pkg::RST_BYTE;
      drop_valid_ff <= 1'b0;
      drop_frame_ff <= 1'b0;
    end else if (ce) begin
      drop_valid_ff <= drop_hit;
      drop_frame_ff <= drop_hit && (line_rx_fs || drop_pend_ff);
      if (line_rx_valid) begin
        rx_slot_ff   <= (rx_slot >= last_slot) ? 4'h0 : rx_slot + 4'h1;
        drop_pend_ff <= (line_rx_fs || drop_pend_ff) && !drop_hit;
      end
      if (drop_hit) begin
        drop_byte_ff <= line_rx_data; // R7
      end
    end
  end

  sts1_scrambler u_tx_scramble (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .en        (scramble_ff),
    .in_valid  (drop_valid_ff),
    .in_fs     (drop_frame_ff),
    .in_data   (drop_byte_ff),
    .out_valid (sts1_tx_valid),
    .out_fs    (sts1_tx_frame),
    .out_data  (sts1_tx_data)
  ); // R8

  // ==========================================================================
  // Outputs
  assign reg_rdata     = reg_rdata_ff;
  assign line_tx_data  = line_tx_data_ff;
  assign line_tx_valid = line_tx_valid_ff;
  assign line_tx_frame = line_tx_frame_ff;
  assign tst_rx_data   = drop_byte_ff;
  assign tst_rx_valid  = drop_valid_ff;
  assign tst_rx_frame  = drop_frame_ff;
  assign sts1_rx_ready = sts1_rx_ready_ff;

endmodule

/* File: test/adm_chk.sv */
`timescale 1ns/100ps
module adm_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       line_tx_en,
  input wire logic       line_tx_fs,
  input wire logic       line_tx_valid,
  input wire logic       line_tx_frame,
  input wire logic [7:0] line_rx_data,
  input wire logic       line_rx_valid,
  input wire logic [7:0] tst_rx_data,
  input wire logic       tst_rx_valid,
  input wire logic       tst_rx_frame,
  input wire logic [7:0] sts1_tx_data,
  input wire logic       sts1_tx_valid,
  input wire logic       sts1_tx_frame
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ====================
  // Line timing and drop path.
  chk_tx_answer: assert property (ce && line_tx_en |=> line_tx_valid)
    else $error("line byte not answered");
  chk_tx_quiet: assert property (ce && !line_tx_en |=> !line_tx_valid)
    else $error("line valid without a slot");
  chk_tx_frame: assert property (ce && line_tx_en && line_tx_fs |=> line_tx_frame)
    else $error("frame start not marked");
  chk_frame_valid: assert property (line_tx_frame |-> line_tx_valid)
    else $error("frame mark without valid");
  chk_drop_data: assert property (tst_rx_valid |-> $past(line_rx_valid) &&
    tst_rx_data == $past(line_rx_data))
    else $error("dropped byte differs from line byte");
  chk_drop_quiet: assert property (ce && !line_rx_valid |=> !tst_rx_valid)
    else $error("drop valid without a line byte");
  chk_sts1_follow: assert property (ce && tst_rx_valid |=> sts1_tx_valid &&
    sts1_tx_frame == $past(tst_rx_frame))
    else $error("electrical output not one cycle after drop");
  chk_sts1_quiet: assert property (ce && !tst_rx_valid |=> !sts1_tx_valid)
    else $error("electrical valid without a drop");
  chk_scr_clear: assert property (tst_rx_frame |=> sts1_tx_data == $past(tst_rx_data))
    else $error("first frame byte altered");
endmodule

bind sts1_channel_add_drop_mux adm_chk u_chk (.clk, .rst, .ce, .line_tx_en, .line_tx_fs,
  .line_tx_valid, .line_tx_frame, .line_rx_data, .line_rx_valid, .tst_rx_data, .tst_rx_valid,
  .tst_rx_frame, .sts1_tx_data, .sts1_tx_valid, .sts1_tx_frame);

/* File: test/sts1_src_model.sv */
`timescale 1ns/100ps
module sts1_src_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       hold,
  input  wire logic       ready,
  output logic      [7:0] data,
  output logic            valid,
  output logic            fs
);
  logic [9:0] pos_ff;
  logic       ph_ff;
  // Sends a byte every other cycle while ready and not held; idle data toggles so it is never mistaken.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      valid <= 1'b0;
      fs <= 1'b0;
      data <= 8'h00;
      pos_ff <= 10'h000;
      ph_ff <= 1'b0;
    end else begin
      ph_ff <= ~ph_ff;
      if (!hold && ready && ph_ff) begin
        valid <= 1'b1;
        data <= 8'hA5;
        fs <= pos_ff == 10'h000;
        pos_ff <= pos_ff == 10'h329 ? 10'h000 : pos_ff + 10'h001;
      end else begin
        valid <= 1'b0;
        fs <= 1'b0;
        data <= ~data;
      end
    end
  end
endmodule

/* File: test/tb_sts1_channel_add_drop_mux.sv */
`timescale 1ns/100ps
module tb_sts1_channel_add_drop_mux;
  logic        clk, rst, ce, reg_wr, reg_rd, hold, line_tx_en, line_tx_fs, line_tx_valid;
  logic        line_tx_frame, line_rx_valid, line_rx_fs, tst_rx_valid, tst_rx_frame;
  logic        sts1_rx_valid, sts1_rx_fs, sts1_rx_ready, sts1_tx_valid, sts1_tx_frame;
  logic [7:0]  reg_addr, tst_tx_data, line_tx_data, line_rx_data, tst_rx_data, c;
  logic [7:0]  sts1_rx_data, sts1_tx_data, lastd, extb, pend;
  logic [31:0] reg_wdata, reg_rdata, ctrl, v;
  logic [3:0]  ins, drp, e;
  int          n_mismatch, checked, cycles, seed, lvl, pos;
  sts1_channel_add_drop_mux dut (.clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .tst_tx_data, .line_tx_en, .line_tx_fs, .line_tx_data, .line_tx_valid,
    .line_tx_frame, .line_rx_data, .line_rx_valid, .line_rx_fs, .tst_rx_data, .tst_rx_valid,
    .tst_rx_frame, .sts1_rx_data, .sts1_rx_valid, .sts1_rx_fs, .sts1_rx_ready,
    .sts1_tx_data, .sts1_tx_valid, .sts1_tx_frame);
  sts1_src_model src (.clk, .rst, .hold, .ready(sts1_rx_ready), .data(sts1_rx_data),
    .valid(sts1_rx_valid), .fs(sts1_rx_fs));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ====================
  // Bus tasks and expectations.
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic setc(input logic [31:0] d);
    wr(adm_pkg::OFS_CTRL, d);
    ctrl = (d[0] && d[9:8] == 2'h2) ? {d[31:10], ctrl[9:8], d[7:0]} : d;
  endtask
  function automatic logic [3:0] slot_of(input logic [7:0] k, input logic [1:0] sch);
    if (sch == 2'h0) return (k[3:0] - 4'h1) * 4'h4 + k[7:4] - 4'h1;
    if (sch == 2'h2) return ((k[3:0] - 4'h1) % 4'h3) * 4'h4 + (k[3:0] - 4'h1) / 4'h3;
    return k[3:0] - 4'h1;
  endfunction
  function automatic logic [7:0] key(input int p);
    logic [6:0] s = 7'h7F;
    logic [7:0] k;
    for (int i = 0; i < (p - 2) * 8; i++) begin
      k = {k[6:0], s[6]};
      s = {s[5:0], s[6] ^ s[5]};
    end
    return k;
  endfunction
  function automatic logic [7:0] exp_tx(input logic [3:0] sl, input logic [7:0] t);
    logic [7:0] ib;
    ib = t;
    if (ctrl[5:4] == 2'h3) ib = ctrl[11:10] == 2'h0 ? extb : ctrl[11:10] == 2'h1 ? 8'h00 : lastd;
    if (sl == ins || ctrl[9:8] == 2'h0) return ib;
    return (ctrl[9:8] == 2'h2 && !ctrl[0]) ? extb : 8'h00;
  endfunction
  // One line round of n slots on transmit and, if asked, receive.
  task automatic round(input int n, input bit fs, input bit rxon, input bit txchk);
    logic [7:0] tq [0:13];
    logic [7:0] rq [0:13];
    int hits = 0;
    for (int i = 0; i <= n + 1; i++) begin
      @(posedge clk);
      tq[i] = 8'($random(seed));
      rq[i] = 8'($random(seed));
      line_tx_en <= i < n;
      line_tx_fs <= i == 0;
      line_rx_valid <= rxon && i < n;
      line_rx_fs <= fs && i == 0;
      tst_tx_data <= tq[i];
      line_rx_data <= rq[i];
      if (i == 0 && (ctrl[9:8] == 2'h2 && !ctrl[0] ||
                     ctrl[5:4] == 2'h3 && ctrl[11:10] == 2'h0)) begin
        extb = lvl > 0 ? 8'hA5 : 8'h00;
        lvl = lvl - 1;
      end
      #1;
      if (txchk && i > 0 && i <= n)
        check(line_tx_data, exp_tx(4'(i - 1), tq[i - 1]));
      if (sts1_tx_valid === 1'b1) check(sts1_tx_data, pend);
      if (tst_rx_valid === 1'b1) begin
        hits++;
        pos = tst_rx_frame ? 0 : pos + 1;
        check(tst_rx_data, rq[i - 1]);
        lastd = rq[i - 1];
        pend = (ctrl[3] && pos >= 3) ? lastd ^ key(pos) : lastd;
      end
    end
    if (rxon) check(hits, drp < n);
  endtask
  // ====================
  // Main sequence.
  initial begin
    seed = 32'h94fa;
    {ce, reg_wr, reg_rd, line_tx_en, line_tx_fs, line_rx_valid, line_rx_fs} = '0;
    {reg_addr, reg_wdata, tst_tx_data, line_rx_data, lastd, pend, extb} = '0;
    {n_mismatch, checked, cycles, pos} = '0;
    {rst, ce, hold} = 3'h7;
    ctrl = 32'h8;
    lvl = 1000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(adm_pkg::OFS_CTRL, v);
    check(v, 32'h0000_0008);
    for (int s = 0; s < 4; s++) begin
      setc(s == 3 ? 32'h0 : 32'(1 | (s << 1)));
      for (int k = 1; k <= (s == 3 ? 4 : 13); k++) begin
        c = s == 0 ? {4'((k - 1) % 4 + 1), 4'((k - 1) / 4 + 1)} : 8'(k);
        if (k < (s == 3 ? 4 : 13)) e = slot_of(c, s[1:0]);
        wr(adm_pkg::OFS_INS, {24'h0, c});
        wr(adm_pkg::OFS_DROP, {24'h0, c});
        rd(adm_pkg::OFS_STATUS, v);
        check(v[7:0], {e, e});
      end
    end
    for (int f = 0; f < 3; f++) begin
      setc(32'hB | ((f * 2 % 3) << 8));
      ins = 4'($unsigned($random(seed)) % 12);
      drp = 4'($unsigned($random(seed)) % 12);
      wr(adm_pkg::OFS_INS, 32'(ins + 1));
      wr(adm_pkg::OFS_DROP, 32'(drp + 1));
      round(12, 1, 1, 1);
      repeat (4) round(12, 0, 1, 1);
    end
    setc(32'h200);
    wr(adm_pkg::OFS_INS, 32'h2);
    wr(adm_pkg::OFS_DROP, 32'h1);
    ins = 4'h1;
    hold <= 1'b0;
    repeat (100) @(posedge clk);
    hold <= 1'b1;
    repeat (6) @(posedge clk);
    check(sts1_rx_ready, 1'b0);
    rd(adm_pkg::OFS_STATUS, v);
    lvl = int'(v[13:8]);
    check(lvl > 27, 1'b1);
    repeat (lvl + 2) round(3, 0, 0, 1);
    rd(adm_pkg::OFS_STATUS, v);
    check(v[13:8], 6'h00);
    hold <= 1'b0;
    lvl = 1000;
    repeat (40) @(posedge clk);
    setc(32'h0);
    wr(adm_pkg::OFS_JOINT, 32'h3);
    rd(adm_pkg::OFS_STATUS, v);
    check(v[7:0], 8'h01);
    for (int d = 0; d < 4; d++) begin
      setc(d == 3 ? 32'h410 : 32'(32'h30 | (d << 10)));
      wr(adm_pkg::OFS_JOINT, 32'h3);
      ins = 4'h2;
      drp = 4'h2;
      rd(adm_pkg::OFS_STATUS, v);
      check(v[7:0], 8'h22);
      round(3, 1, 1, d != 2);
      round(3, 0, 0, 1);
    end
    stop_test();
  end
endmodule
